//--- hdl/acbms_pkg.sv
// Package for the control-byte decoder and track/hold sequencer.
// Assumes a single system clock domain; serial pins are synchronised inside.
package acbms_pkg;
    // Control-byte field positions
    localparam int unsigned BIT_START     = 7;
    localparam int unsigned BIT_SEL_HI    = 6;
    localparam int unsigned BIT_SEL_MID   = 5;
    localparam int unsigned BIT_SEL_LO    = 4;
    localparam int unsigned BIT_POLARITY  = 3;
    localparam int unsigned BIT_INPUT_CFG = 2;
    localparam int unsigned BIT_POWER     = 1;
    localparam int unsigned BIT_CLK_SRC   = 0;
    // Byte and channel sizes, and the bit count at which tracking starts
    localparam int unsigned BYTE_BITS     = 8;
    localparam int unsigned NUM_CHAN      = 8;
    localparam int unsigned TRACK_AT_BIT  = 6;
    // Conversion length in serial clocks after hold
    localparam logic [3:0]  CONV_CLOCKS   = 4'h8;
    // Negative-input code for the common pin
    localparam logic [3:0]  MUX_COM       = 4'h8;
    // Reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [3:0]  MUX_RESET     = 4'h0;
    // Least acquisition time, host side, in ns, and in system clocks
    localparam int unsigned CLK_SYS_NS       = 20;
    localparam int unsigned ACQUIRE_TIME_MIN = 1000;
    localparam int unsigned ACQUIRE_CYCLES   =
        (ACQUIRE_TIME_MIN + CLK_SYS_NS - 1) / CLK_SYS_NS;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ACBMS_IDLE  = 4'b0001,
        ACBMS_SHIFT = 4'b0010,
        ACBMS_CONV  = 4'b0100,
        ACBMS_DONE  = 4'b1000
    } acbms_state_t;
endpackage

//--- hdl/acbms_link_if.sv
// Interface carrying synchronised serial link events between the modules.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface acbms_link_if;
    logic rise;   // Serial clock rising edge seen
    logic fall;   // Serial clock falling edge seen
    logic data;   // Serial data, synchronised
    logic sel;    // Chip select active, synchronised
    logic select_fall;  // Chip select went active
    modport src (output rise, fall, data, sel, select_fall);
    modport dst (input  rise, fall, data, sel, select_fall);
endinterface
`default_nettype wire

//--- hdl/acbms_pin_sync.sv
// Pin synchroniser and edge finder for the serial link pins.
// Assumes pins are asynchronous to clk_sys; two flops before any logic.
`timescale 1ns/1ps
`default_nettype none
module acbms_pin_sync (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       sclk,
    input  wire logic       din,
    input  wire logic       cs_n,
    acbms_link_if.src       link
);
    import acbms_pkg::*;

    typedef struct packed {
        logic [2:0] s1;   // First stage: sclk, din, cs_n
        logic [2:0] s2;   // Second stage
        logic [1:0] prev; // Previous sclk, cs_n
    } acbms_sync_t;

    acbms_sync_t st;
    acbms_sync_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st      = st;
        next_st.s1   = {sclk, din, cs_n};
        next_st.s2   = st.s1;
        next_st.prev = {st.s2[2], st.s2[0]};
    end

    // Register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '{s1: 3'b001, s2: 3'b001, prev: 2'b01};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Edge detection compares the second stage with the previous values
    assign link.rise        = clk_en & st.s2[2] & ~st.prev[1];
    assign link.fall        = clk_en & ~st.s2[2] & st.prev[1];
    assign link.data        = st.s2[1];
    assign link.sel         = ~st.s2[0];
    assign link.select_fall = clk_en & ~st.s2[0] & st.prev[0];
endmodule
`default_nettype wire

//--- hdl/acbms_top.sv
// Control-byte decoder, input multiplexer and track/hold sequencer.
// Assumes serial pins asynchronous to clk_sys, host keeps link timing.
// Function
// R1: Start tracking on serial clock fall after sixth control bit.
// R2: Enter hold on serial clock fall after eighth control bit.
// R3: Single-ended: negative side to common pin, sample positive channel.
// R4: Differential: negative side to paired channel, convert the difference.
// R5: After conversion, reconnect capacitor to the positive input.
// R6: Eight-channel single-ended codes 000,100,001.. map channels 0 to 7.
// R7: Eight-channel differential: low bits pick pair, top bit picks polarity.
// R8: Four-channel variant ignores lowest select bit.
// R9: First one bit after select falls is start of control byte.
// R10: Bits 6 to 4 form the channel-select field.
// R11: Bit 3 one means unipolar, zero bipolar.
// R12: Bit 2 one means single-ended, zero differential.
// R13: Bit 1 one keeps power on, zero powers down.
// R14: Bit 0 one external clock, zero internal clock.
// R15: Unipolar differential with negative input gives invalid code zero.
// R16: Host sends a full control byte before every conversion.
// R17: Host keeps tracking interval at least one microsecond.
// R18: Acquisition spans two serial clocks, ends on fall after last bit.
// R19: Data input is sampled on rising serial clock edges.
// R20: Zero bits before the start bit are ignored.
// R21: Conversion begins on serial clock fall after eighth bit.
// R22: All control fields latch together at the eighth bit.
`timescale 1ns/1ps
`default_nettype none
module acbms_top (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       four_chan,
    input  wire logic       sclk,
    input  wire logic       din,
    input  wire logic       cs_n,
    input  wire logic       diff_negative,
    output logic            track,
    output logic            hold,
    output logic            converting,
    output logic [3:0]      mux_pos,
    output logic [3:0]      mux_neg,
    output logic            polarity_select,
    output logic            input_config_select,
    output logic            power_keep_on,
    output logic            conv_clock_source,
    output logic [2:0]      chan_sel,
    output logic            force_zero,
    output logic            byte_done
);
    import acbms_pkg::*;

    typedef struct packed {
        acbms_state_t state;
        logic [7:0]   shreg;
        logic [2:0]   bit_cnt;    // Bits taken, the start bit included
        logic [7:0]   ctrl;       // Latched control byte
        logic [3:0]   conv_cnt;
        logic         track;
        logic         hold;
        logic [3:0]   chan;       // Decoded positive channel
        logic [3:0]   pair;       // Decoded negative channel
        logic         byte_done;
        logic         pending;    // Eighth bit taken, waiting for fall
    } acbms_reg_t;

    acbms_reg_t   st;
    acbms_reg_t   next_st;
    acbms_link_if link ();

    logic [7:0]   full_byte;
    logic [3:0]   dec_pos;
    logic [3:0]   dec_neg;
    logic [2:0]   sel;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    acbms_pin_sync u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .sclk    (sclk),
        .din     (din),
        .cs_n    (cs_n),
        .link    (link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Channel decode from the byte just completed
    always_comb begin
        full_byte = {st.shreg[6:0], link.data};
        sel       = full_byte[BIT_SEL_HI:BIT_SEL_LO];    // R10
        if (four_chan) begin
            sel[0] = 1'b0;                                // R8
        end
        // Single-ended channel number is {mid, lo, hi}
        if (full_byte[BIT_INPUT_CFG]) begin
            dec_pos = {1'b0, sel[1], sel[0], sel[2]};     // R6
            if (four_chan) begin
                dec_pos = {2'b00, sel[1], sel[2]};        // R8
            end
            dec_neg = MUX_COM;                            // R3
        end else begin
            // Pair index from lower bits, polarity from top bit
            dec_pos = {1'b0, sel[1], sel[0], sel[2]};     // R7
            dec_neg = {1'b0, sel[1], sel[0], ~sel[2]};    // R4
            if (four_chan) begin
                dec_pos = {2'b00, sel[1], sel[2]};        // R8
                dec_neg = {2'b00, sel[1], ~sel[2]};       // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        next_st           = st;
        next_st.byte_done = 1'b0;
        unique case (st.state)
            ACBMS_IDLE: begin
                if (link.sel && link.rise && link.data) begin   // R9 R19 R20
                    next_st.state   = ACBMS_SHIFT;
                    next_st.shreg   = 8'h01;
                    next_st.bit_cnt = 3'h1;
                end
            end
            ACBMS_SHIFT: begin
                if (!link.sel) begin
                    next_st.state = ACBMS_IDLE;
                    next_st.track = 1'b0;
                    // A cut after the eighth bit must not hold in the next frame
                    next_st.pending = 1'b0;
                end else if (link.rise && !st.pending) begin    // R19
                    next_st.shreg   = full_byte;
                    next_st.bit_cnt = st.bit_cnt + 3'h1;
                    if (st.bit_cnt == 3'(BYTE_BITS - 1)) begin
                        next_st.pending = 1'b1;
                        next_st.ctrl    = full_byte;            // R22
                        next_st.chan    = dec_pos;
                        next_st.pair    = dec_neg;
                        next_st.byte_done = 1'b1;
                    end
                end else if (link.fall) begin
                    if (st.bit_cnt == 3'(TRACK_AT_BIT)) begin
                        next_st.track = 1'b1;                   // R1 R18
                    end
                    if (st.pending) begin
                        next_st.track    = 1'b0;                // R2 R18
                        next_st.hold     = 1'b1;                // R2
                        next_st.pending  = 1'b0;
                        next_st.conv_cnt = 4'h0;
                        next_st.state    = ACBMS_CONV;          // R21
                    end
                end
            end
            ACBMS_CONV: begin
                if (link.select_fall) begin
                    next_st.hold  = 1'b0;
                    next_st.state = ACBMS_IDLE;
                end else if (link.fall) begin
                    next_st.conv_cnt = st.conv_cnt + 4'h1;
                    if (st.conv_cnt == CONV_CLOCKS - 4'h1) begin
                        next_st.state = ACBMS_DONE;
                    end
                end
            end
            ACBMS_DONE: begin
                next_st.hold  = 1'b0;                           // R5
                next_st.state = ACBMS_IDLE;                     // R16
            end
            // Illegal one-hot code: fall back to idle
            default: begin
                next_st.state = ACBMS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '{state: ACBMS_IDLE, shreg: CTRL_RESET, bit_cnt: 3'h0,
                    ctrl: CTRL_RESET, conv_cnt: 4'h0, track: 1'b0,
                    hold: 1'b0, chan: MUX_RESET, pair: MUX_COM,
                    byte_done: 1'b0, pending: 1'b0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign track               = st.track;
    assign hold                = st.hold;
    assign converting          = st.hold;
    assign mux_pos             = st.chan;                          // R5
    assign mux_neg             = st.pair;
    assign chan_sel            = st.ctrl[BIT_SEL_HI:BIT_SEL_LO];   // R10
    assign polarity_select     = st.ctrl[BIT_POLARITY];            // R11
    assign input_config_select = st.ctrl[BIT_INPUT_CFG];           // R12
    assign power_keep_on       = st.ctrl[BIT_POWER];               // R13
    assign conv_clock_source   = st.ctrl[BIT_CLK_SRC];             // R14
    assign byte_done           = st.byte_done;
    // Unipolar differential with negative input forces code zero
    assign force_zero          = st.ctrl[BIT_POLARITY] & ~st.ctrl[BIT_INPUT_CFG]
                                 & diff_negative;                  // R15
endmodule
`default_nettype wire

//--- verif/acbms_assertions.sv
// Checker on the ports of the control-byte sequencer top.
// Assumes it is bound onto acbms_top, single clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module acbms_assertions (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       four_chan,
    input wire logic       diff_negative,
    input wire logic       track,
    input wire logic       hold,
    input wire logic [3:0] mux_pos,
    input wire logic [3:0] mux_neg,
    input wire logic       polarity_select,
    input wire logic       input_config_select,
    input wire logic [2:0] chan_sel,
    input wire logic       force_zero,
    input wire logic       byte_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Multiplexer decode against the latched select field
    AST_SGL_COMMON: assert property (input_config_select |-> mux_neg == 4'h8)
        else $error("negative side not on common pin");
    AST_DIFF_PAIR: assert property (byte_done && !input_config_select && !four_chan
        |-> mux_neg == {1'b0, chan_sel[1:0], ~chan_sel[2]}) else $error("bad pair minus");
    AST_EIGHT_MAP: assert property (byte_done && !four_chan
        |-> mux_pos == {1'b0, chan_sel[1:0], chan_sel[2]}) else $error("bad positive channel");
    AST_FOUR_MAP: assert property (byte_done && four_chan
        |-> mux_pos == {2'b00, chan_sel[1], chan_sel[2]}) else $error("bad four-chan channel");
    AST_ZERO_CODE: assert property (force_zero ==
        (polarity_select && !input_config_select && diff_negative)) else $error("bad zero code");
    // Track and hold sequencing around the last bit
    AST_TRACK_WINDOW: assert property (byte_done |-> track && !hold)
        else $error("not tracking at last bit");
    AST_HOLD_AFTER: assert property (byte_done |-> ##[1:20] $rose(hold))
        else $error("hold late");
    AST_TRACK_ENDS: assert property ($rose(hold) |-> $fell(track))
        else $error("track not ended by hold");
    AST_FIELDS_STABLE: assert property (hold |-> $stable({chan_sel, polarity_select}))
        else $error("fields moved in conversion");
endmodule
bind acbms_top acbms_assertions chk_u (.clk_sys, .reset, .four_chan, .diff_negative,
    .track, .hold, .mux_pos, .mux_neg, .polarity_select, .input_config_select,
    .chan_sel, .force_zero, .byte_done);
`default_nettype wire

//--- verif/acbms_host_model.sv
// Serial host model shifting control bytes into the sequencer.
// Assumes link clock idles low and data is taken on its rise.
`timescale 1ns/1ps
`default_nettype none
module acbms_host_model (
    output var logic sclk,
    output var logic din,
    output var logic cs_n
);
    initial begin
        sclk = 1'b0;
        din  = 1'b1;
        cs_n = 1'b1;
    end
    // Whole frame: leading zeros, one byte, eight conversion clocks
    task automatic xfer(input logic [7:0] b, input int unsigned z);
        int unsigned k;
        int unsigned hp;
        cs_n = 1'b0;
        #200;
        for (k = 0; k < z + 16; k++) begin
            din = (k < z || k >= z + 8) ? 1'b0 : b[z + 7 - k];
            hp = (k == z + 6 || k == z + 7) ? 260 : 80;
            #hp sclk = 1'b1;
            #hp sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        din = ~din;
        // Chip select stays high a while between frames
        #200;
    endtask
    // Cut frame: chip select released after n bits of byte b
    task automatic cut(input logic [7:0] b, input int unsigned n);
        int unsigned k;
        cs_n = 1'b0;
        #200;
        for (k = 0; k < n; k++) begin
            din = b[7 - k];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        din = ~din;
        #200;
    endtask
endmodule
`default_nettype wire

//--- verif/acbms_tb_top.sv
// Testbench for the control-byte sequencer top.
// Assumes the host model drives the serial pins on its own timing.
`timescale 1ns/1ps
`default_nettype none
module acbms_tb_top;
    logic       clk_sys, reset, clk_en, four_chan, diff_negative;
    logic       sclk, din, cs_n, track, hold, converting, force_zero, byte_done;
    logic [3:0] mux_pos, mux_neg;
    logic       polarity_select, input_config_select, power_keep_on, conv_clock_source;
    logic [2:0] chan_sel;
    int         error_cnt = 0, n_checks = 0, n_done = 0, n_rise = 0;
    int         n_track = 0, n_conv = 0;

    acbms_top dut_u (.clk_sys, .reset, .clk_en, .four_chan, .sclk, .din, .cs_n,
        .diff_negative, .track, .hold, .converting, .mux_pos, .mux_neg, .polarity_select,
        .input_config_select, .power_keep_on, .conv_clock_source, .chan_sel,
        .force_zero, .byte_done);
    acbms_host_model host_u (.sclk, .din, .cs_n);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Count completed bytes and hold, track and converting entries
    always @(posedge clk_sys) if (byte_done === 1'b1) n_done++;
    always @(posedge hold) n_rise++;
    always @(posedge track) n_track++;
    always @(posedge converting) n_conv++;

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One frame, then judge fields and multiplexer
    task automatic run(input logic [7:0] b, input int unsigned z, input logic f);
        logic [3:0] p, n;
        int         k, d0, r0, t0, c0;
        @(negedge clk_sys);
        four_chan = f;
        d0 = n_done;
        r0 = n_rise;
        t0 = n_track;
        c0 = n_conv;
        k = 0;
        host_u.xfer(b, z);
        while (hold !== 1'b0 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 20) begin
            error_cnt++;
            report_and_stop();
        end
        p = f ? {2'b00, b[5], b[6]} : {1'b0, b[5], b[4], b[6]};
        n = b[2] ? 4'h8 : {p[3:1], ~p[0]};
        chk("byte_count", 8'(d0 + 1), 8'(n_done));
        chk("hold_count", 8'(r0 + 1), 8'(n_rise));
        chk("track_count", 8'(t0 + 1), 8'(n_track));
        chk("conv_count", 8'(c0 + 1), 8'(n_conv));
        chk("mux_pos", {4'h0, p}, {4'h0, mux_pos});
        chk("mux_neg", {4'h0, n}, {4'h0, mux_neg});
        chk("chan_sel", {5'h00, b[6:4]}, {5'h00, chan_sel});
        chk("mode_bits", {4'h0, b[3:0]}, {4'h0, polarity_select, input_config_select,
            power_keep_on, conv_clock_source});
    endtask

    // All select codes, both input modes, both variants, varied lead-in
    task automatic sc_modes();
        logic [5:0] i;
        for (int j = 0; j < 64; j++) begin
            i = 6'(j);
            run({1'b1, i[2:0], i[5], i[3], ~i[5], i[4] ^ i[0]}, j % 3, i[4]);
        end
    endtask

    // Zero code only for unipolar differential with negative input
    task automatic sc_zero_code();
        logic [7:0] t [3] = '{8'h8B, 8'h83, 8'h8F};
        for (int j = 0; j < 3; j++) begin
            run(t[j], 1, 1'b0);
            for (int d = 0; d < 2; d++) begin
                @(negedge clk_sys);
                diff_negative = d[0];
                @(negedge clk_sys);
                chk("force_zero", {7'h00, t[j][3] & ~t[j][2] & d[0]}, {7'h00, force_zero});
            end
        end
    endtask

    // Chip select released mid-byte: no byte, no hold, tracking dropped
    task automatic sc_abort();
        int d0, r0;
        d0 = n_done;
        r0 = n_rise;
        host_u.cut(8'hF7, 7);
        chk("cut_count", 8'(d0), 8'(n_done));
        chk("cut_hold", 8'(r0), 8'(n_rise));
        chk("cut_track", 8'h00, {7'h00, track});
        run(8'hF7, 0, 1'b0);
    endtask

    // Clock enable low: a whole frame passes unseen and nothing moves
    task automatic sc_freeze();
        logic [2:0] s0;
        int         d0, r0;
        @(negedge clk_sys);
        s0 = chan_sel;
        d0 = n_done;
        r0 = n_rise;
        clk_en = 1'b0;
        host_u.xfer(8'h8F, 1);
        @(negedge clk_sys);
        clk_en = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("frozen_count", 8'(d0), 8'(n_done));
        chk("frozen_hold", 8'(r0), 8'(n_rise));
        chk("frozen_sel", {5'h00, s0}, {5'h00, chan_sel});
    endtask

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        four_chan = 1'b0;
        diff_negative = 1'b0;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        sc_modes();
        sc_zero_code();
        sc_abort();
        sc_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
